// ### core/hall_conditioning.sv
// top of the field conditioning chain with parameter store, lock and command handling
// assumes a demodulator delivers decoded commands and a serialiser sends the reply
`timescale 1ns/1ps
module hall_conditioning
#(
   parameter int                REPLY_CYCLES = hall_cond_pkg::REPLY_HOLD,
   parameter logic [15:0]       TRIM_OSC     = 16'h0000, // arbitrary factory value
   parameter logic [15:0]       TRIM_ADC     = 16'h0000, // arbitrary factory value
   parameter logic [15:0]       TRIM_SPEC    = 16'h0000  // arbitrary factory value
)
(
   input  wire logic                                   clock,         // 50 MHz clock
   input  wire logic                                   rstn,          // async reset, low
   input  wire logic                                   sample_valid,  // converter strobe
   input  wire logic signed [hall_cond_pkg::SAMPLE_W-1:0] sample_data, // signed sample
   input  wire logic                                   cmd_valid,     // command strobe
   output logic                                        cmd_ready,     // idle, may accept
   input  wire logic                                   cmd_write,     // 1 write, 0 read
   input  wire logic [hall_cond_pkg::ADDR_W-1:0]       cmd_addr,      // register index
   input  wire logic [hall_cond_pkg::DATA_W-1:0]       cmd_wdata,     // write data
   input  wire logic                                   select_pin,    // output pin select
   output logic                                        resp_valid,    // reply strobe
   output logic [hall_cond_pkg::DATA_W-1:0]            resp_data,     // reply word
   output logic                                        out_pin_oe,    // digital reply drive
   output logic                                        analog_enable, // analog stage on
   output logic                                        dac_valid,     // new output code
   output logic [hall_cond_pkg::DAC_W-1:0]             dac_code,      // output code
   output logic [hall_cond_pkg::SEL_W-1:0]             range_sel,     // converter range
   output logic [7:0]                                  range_mt,      // range in mT
   output logic [hall_cond_pkg::DATA_W-1:0]            lin_temp_coefficient,  // slope
   output logic [hall_cond_pkg::DATA_W-1:0]            quad_temp_coefficient, // curvature
   output logic                                        locked         // lock state
);
   import hall_cond_pkg::*;

   typedef struct packed {
      ctrl_state_type      st;
      logic [2:0]          sync;
      logic                selected;
      logic                lock;
      logic                wr;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wd;
      logic [HOLD_W-1:0]   cnt;
      logic                resp_v;
      logic [DATA_W-1:0]   resp_d;
      logic                pin_oe;
      logic                dac_v;
      logic [DAC_W-1:0]    dac;
   } ctrl_type;

   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(REPLY_CYCLES - 1);

   ctrl_type st_r;
   ctrl_type st_nxt;

   logic                          accept;
   logic                          mem_we;
   logic [DATA_W-1:0]             mem_rd;
   logic [STORE_DEPTH-1:0][DATA_W-1:0] words;
   logic                          filt_v;
   logic signed [SAMPLE_W-1:0]    filt;
   logic [SEL_W-1:0]              filter_code;
   logic signed [SUM_W-1:0]       lo_eff;
   logic signed [SUM_W-1:0]       hi_eff;

   assign filter_code = words[ADDR_MODE][FILTER_LSB +: SEL_W];
   assign range_sel   = words[ADDR_MODE][RANGE_LSB +: SEL_W];
   assign range_mt    = hall_cond_pkg::range_mt(range_sel);
   assign lin_temp_coefficient  = words[ADDR_LIN_COEF];
   assign quad_temp_coefficient = words[ADDR_QUAD_COEF];

   // selection, lock and idle all gate the command
   assign accept = cmd_valid && st_r.st == st_idle && st_r.selected && !st_r.lock;
   assign mem_we = accept && cmd_write && cmd_addr <= ADDR_QUAD_COEF;

   param_store #(.DEPTH(STORE_DEPTH), .W(DATA_W)) u_store (
      .clock   (clock),
      .rstn    (rstn),
      .wr_en   (mem_we),
      .wr_addr (cmd_addr),
      .wr_data (cmd_wdata),
      .rd_addr (cmd_addr),
      .rd_data (mem_rd),
      .words   (words)
   );

   lp_filter #(.SW(SAMPLE_W), .FRAC(FILT_FRAC_BITS)) u_filter (
      .clock       (clock),
      .rstn        (rstn),
      .in_valid    (sample_valid),
      .in_data     (sample_data),
      .filter_code (filter_code),
      .out_valid   (filt_v),
      .out_data    (filt)
   );

   // clamp window, upper limit never above one supply span
   always_comb
   begin
      lo_eff = SUM_W'(signed'({1'b0, words[ADDR_CLAMP_LOW][DAC_W-1:0]}));
      hi_eff = SUM_W'(signed'({1'b0, words[ADDR_CLAMP_HIGH][DAC_W-1:0]}));
      if (hi_eff > SUM_W'(signed'({1'b0, OUT_FULL_SCALE})))
         hi_eff = SUM_W'(signed'({1'b0, OUT_FULL_SCALE}));
   end

   always_comb
   begin
      logic signed [SUM_W-1:0] prod;
      logic signed [SUM_W-1:0] sum;
      prod   = '0;
      sum    = '0;
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[1:0], select_pin};
      if (st_r.sync[1] == st_r.sync[2])
         st_nxt.selected = st_r.sync[2];
      st_nxt.resp_v = 1'b0;
      st_nxt.dac_v  = 1'b0;

      // output characteristic from sensitivity, quiescent and both clamps
      prod = SUM_W'(filt) * SUM_W'(signed'(words[ADDR_SENS]));
      sum  = (prod >>> SENS_FRAC_BITS)
           + (SUM_W'(signed'(words[ADDR_QUIET])) <<< QUIET_SHIFT);
      if (filt_v)
      begin
         if (sum > hi_eff)
            sum = hi_eff;
         if (sum < lo_eff)
            sum = lo_eff;
         st_nxt.dac   = DAC_W'(sum);
         st_nxt.dac_v = 1'b1;
      end

      case (st_r.st)
         st_idle:
         begin
            if (accept)
            begin
               st_nxt.st   = st_access;
               st_nxt.wr   = cmd_write;
               st_nxt.addr = cmd_addr;
               st_nxt.wd   = cmd_wdata;
               if (cmd_write && cmd_addr == ADDR_LOCK && (cmd_wdata & LOCK_BIT) != '0)
                  st_nxt.lock = 1'b1;
            end
         end
         st_access:
         begin
            st_nxt.st     = st_reply;
            st_nxt.resp_v = 1'b1;
            st_nxt.pin_oe = 1'b1;
            st_nxt.cnt    = HOLD_LAST;
            if (st_r.wr)
               st_nxt.resp_d = st_r.wd;
            else if (st_r.addr <= ADDR_QUAD_COEF)
               st_nxt.resp_d = mem_rd;
            else if (st_r.addr == ADDR_LOCK)
               st_nxt.resp_d = st_r.lock ? LOCK_BIT : '0;
            else if (st_r.addr == ADDR_TRIM_OSC)
               st_nxt.resp_d = TRIM_OSC;
            else if (st_r.addr == ADDR_TRIM_ADC)
               st_nxt.resp_d = TRIM_ADC;
            else if (st_r.addr == ADDR_TRIM_SPEC)
               st_nxt.resp_d = TRIM_SPEC;
            else if (st_r.addr == ADDR_RAW)
               st_nxt.resp_d = DATA_W'(filt);
            else
               st_nxt.resp_d = '0;
         end
         st_reply:
         begin
            if (st_r.cnt == '0)
            begin
               st_nxt.st     = st_idle;
               st_nxt.pin_oe = 1'b0;
            end
            else
               st_nxt.cnt = st_r.cnt - 1'b1;
         end
         default:
         begin
            st_nxt.st     = st_idle;
            st_nxt.pin_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign cmd_ready     = st_r.st == st_idle;
   assign analog_enable = st_r.st == st_idle && !st_r.pin_oe;
   assign resp_valid    = st_r.resp_v;
   assign resp_data     = st_r.resp_d;
   assign out_pin_oe    = st_r.pin_oe;
   assign dac_valid     = st_r.dac_v;
   assign dac_code      = st_r.dac;
   assign locked        = st_r.lock;

   sequence s_accepted;
      accept;
   endsequence

   sequence s_access_then_reply;
      (st_r.st == st_access) ##1 (resp_valid && out_pin_oe);
   endsequence

   a_lock_sticky: assert property (@(posedge clock) disable iff (!rstn)
      locked |=> locked)
      else $error("lock bit cleared");

   a_lock_no_write: assert property (@(posedge clock) disable iff (!rstn)
      locked |=> $stable(words))
      else $error("store written while locked");

   a_locked_ignore: assert property (@(posedge clock) disable iff (!rstn)
      (locked && cmd_ready && cmd_valid) |=> cmd_ready && !resp_valid)
      else $error("locked device acted on command");

   a_unselected_ignore: assert property (@(posedge clock) disable iff (!rstn)
      (!st_r.selected && cmd_ready && cmd_valid) |=> cmd_ready)
      else $error("unselected device acted on command");

   a_select_agree: assert property (@(posedge clock) disable iff (!rstn)
      $changed(st_r.selected) |-> st_r.selected == $past(st_r.sync[2])
         && $past(st_r.sync[1]) == $past(st_r.sync[2]))
      else $error("selection taken before sync agreed");

   a_reply_after: assert property (@(posedge clock) disable iff (!rstn)
      s_accepted |=> s_access_then_reply)
      else $error("no reply after command");

   a_analog_off: assert property (@(posedge clock) disable iff (!rstn)
      s_accepted |=> (!analog_enable && !cmd_ready) [*2])
      else $error("analog on in exchange");

   a_reply_once: assert property (@(posedge clock) disable iff (!rstn)
      resp_valid |=> !resp_valid && out_pin_oe)
      else $error("reply strobe not single");

   a_reply_steady: assert property (@(posedge clock) disable iff (!rstn)
      $changed(resp_data) |-> resp_valid)
      else $error("reply word changed without strobe");

   a_oe_window: assert property (@(posedge clock) disable iff (!rstn)
      $rose(out_pin_oe) |-> resp_valid && !analog_enable)
      else $error("reply drive outside reply");

   a_ready_back: assert property (@(posedge clock) disable iff (!rstn)
      (st_r.st == st_reply && st_r.cnt == '0) |=> cmd_ready && !out_pin_oe)
      else $error("port not idle after reply");

   a_trim_readonly: assert property (@(posedge clock) disable iff (!rstn)
      (cmd_valid && cmd_write && cmd_addr > ADDR_QUAD_COEF) |=> $stable(words))
      else $error("read-only register written");

   a_dac_follows: assert property (@(posedge clock) disable iff (!rstn)
      filt_v |=> dac_valid)
      else $error("output code not updated");

   a_dac_steady: assert property (@(posedge clock) disable iff (!rstn)
      !filt_v |=> $stable(dac_code))
      else $error("output code changed without sample");

   a_raw_in_span: assert property (@(posedge clock) disable iff (!rstn)
      filt_v |-> int'(filt) <= span_hi($past(filter_code))
         && int'(filt) >= span_lo($past(filter_code)))
      else $error("raw sample outside span");

   a_dac_clamped: assert property (@(posedge clock) disable iff (!rstn)
      (dac_valid && $past(lo_eff) <= $past(hi_eff))
      |-> (SUM_W'(signed'({1'b0, dac_code})) >= $past(lo_eff)
           && SUM_W'(signed'({1'b0, dac_code})) <= $past(hi_eff)))
      else $error("output code outside clamps");
endmodule : hall_conditioning

// ### core/hall_cond_pkg.sv
// constants, register map, field layout and lookup functions of the field conditioning chain
// assumes one 50 MHz clock and a command port fed by a supply-modulation demodulator
package hall_cond_pkg;
   localparam int DATA_W         = 16;
   localparam int ADDR_W         = 4;
   localparam int SAMPLE_W       = 14;
   localparam int DAC_W          = 12;
   localparam int SEL_W          = 3;
   localparam int RANGE_LSB      = 0;
   localparam int FILTER_LSB     = 3;
   localparam int MODE_W         = 6;
   localparam int SENS_FRAC_BITS = 11;
   localparam int QUIET_SHIFT    = 1;
   localparam int FILT_FRAC_BITS = 8;
   localparam int STORE_DEPTH    = 7;
   localparam int REPLY_HOLD     = 4;
   localparam int HOLD_W         = 8;
   localparam int SUM_W          = 32;

   localparam logic [ADDR_W-1:0] ADDR_MODE       = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SENS       = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_QUIET      = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_CLAMP_LOW  = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CLAMP_HIGH = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_LIN_COEF   = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_QUAD_COEF  = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_LOCK       = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_TRIM_OSC   = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_TRIM_ADC   = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_TRIM_SPEC  = 4'ha;
   localparam logic [ADDR_W-1:0] ADDR_RAW        = 4'hb;

   localparam logic [DATA_W-1:0] MODE_RESET       = 16'h0000;
   localparam logic [DATA_W-1:0] SENS_RESET       = 16'h0800;
   localparam logic [DATA_W-1:0] QUIET_RESET      = 16'h0200;
   localparam logic [DATA_W-1:0] CLAMP_LOW_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] CLAMP_HIGH_RESET = 16'h0800;
   localparam logic [DATA_W-1:0] COEF_RESET       = 16'h0000;
   localparam logic [DATA_W-1:0] LOCK_BIT         = 16'h0001;
   localparam logic [DAC_W-1:0]  OUT_FULL_SCALE   = 12'h800;

   typedef enum logic [1:0] {
      st_idle   = 2'b00,
      st_access = 2'b01,
      st_reply  = 2'b10
   } ctrl_state_type;

   function automatic logic [DATA_W-1:0] reset_word(input int idx);
      case (idx)
         1:       reset_word = SENS_RESET;
         2:       reset_word = QUIET_RESET;
         3:       reset_word = CLAMP_LOW_RESET;
         4:       reset_word = CLAMP_HIGH_RESET;
         5, 6:    reset_word = COEF_RESET;
         default: reset_word = MODE_RESET;
      endcase
   endfunction : reset_word

   // filter corner codes 0..4; reserved codes fall back to the lowest corner
   function automatic int filter_shift(input logic [SEL_W-1:0] code);
      case (code)
         3'h1:    filter_shift = 6;
         3'h2:    filter_shift = 4;
         3'h3:    filter_shift = 3;
         3'h4:    filter_shift = 2;
         default: filter_shift = 7;
      endcase
   endfunction : filter_shift

   function automatic int span_hi(input logic [SEL_W-1:0] code);
      case (code)
         3'h1:    span_hi = 1985;
         3'h2:    span_hi = 5290;
         3'h3:    span_hi = 2645;
         3'h4:    span_hi = 1511;
         default: span_hi = 3967;
      endcase
   endfunction : span_hi

   function automatic int span_lo(input logic [SEL_W-1:0] code);
      case (code)
         3'h1:    span_lo = -1985;
         3'h2:    span_lo = -5292;
         3'h3:    span_lo = -2646;
         3'h4:    span_lo = -1512;
         default: span_lo = -3968;
      endcase
   endfunction : span_lo

   function automatic logic [7:0] range_mt(input logic [SEL_W-1:0] code);
      case (code)
         3'h4:    range_mt = 8'h28;
         3'h5:    range_mt = 8'h3c;
         3'h1:    range_mt = 8'h4b;
         3'h6:    range_mt = 8'h50;
         3'h2:    range_mt = 8'h5a;
         3'h7:    range_mt = 8'h64;
         3'h3:    range_mt = 8'h96;
         default: range_mt = 8'h1e;
      endcase
   endfunction : range_mt
endpackage : hall_cond_pkg

// ### core/param_store.sv
// nonvolatile parameter words of the customer-writable group
// assumes the caller gates writes with lock and selection
`timescale 1ns/1ps
module param_store
#(
   parameter int DEPTH = hall_cond_pkg::STORE_DEPTH,
   parameter int W     = hall_cond_pkg::DATA_W
)
(
   input  wire logic                                 clock,   // system clock
   input  wire logic                                 rstn,    // async reset, low
   input  wire logic                                 wr_en,   // write strobe
   input  wire logic [hall_cond_pkg::ADDR_W-1:0]     wr_addr, // write word index
   input  wire logic [W-1:0]                         wr_data, // write data
   input  wire logic [hall_cond_pkg::ADDR_W-1:0]     rd_addr, // read word index
   output logic      [W-1:0]                         rd_data, // registered read data
   output logic      [DEPTH-1:0][W-1:0]              words    // all stored words
);
   import hall_cond_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rd;
   } store_type;

   function automatic store_type store_init();
      store_type s;
      s.rd = '0;
      for (int i = 0; i < DEPTH; i++)
         s.mem[i] = W'(reset_word(i));
      return s;
   endfunction : store_init

   localparam store_type STORE_RESET = store_init();

   store_type st_r;
   store_type st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (int'(rd_addr) < DEPTH)
         st_nxt.rd = st_r.mem[rd_addr];
      else
         st_nxt.rd = '0;
      if (wr_en && int'(wr_addr) < DEPTH)
         st_nxt.mem[wr_addr] = wr_data;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_r <= STORE_RESET;
      else
         st_r <= st_nxt;
   end

   assign rd_data = st_r.rd;
   assign words   = st_r.mem;
endmodule : param_store

// ### core/lp_filter.sv
// first-order digital low-pass on the converted field samples
// assumes samples arrive as one-cycle strobes from the converter on the same clock
`timescale 1ns/1ps
module lp_filter
#(
   parameter int SW   = hall_cond_pkg::SAMPLE_W,
   parameter int FRAC = hall_cond_pkg::FILT_FRAC_BITS
)
(
   input  wire logic                               clock,       // system clock
   input  wire logic                               rstn,        // async reset, low
   input  wire logic                               in_valid,    // sample strobe
   input  wire logic signed [SW-1:0]               in_data,     // signed sample
   input  wire logic [hall_cond_pkg::SEL_W-1:0]    filter_code, // corner select
   output logic                                    out_valid,   // filtered strobe
   output logic signed [SW-1:0]                    out_data     // filtered sample
);
   import hall_cond_pkg::*;

   localparam int AW = SW + FRAC + 1;

   typedef struct packed {
      logic signed [AW-1:0] acc;
      logic                 v;
      logic signed [SW-1:0] y;
   } filt_type;

   filt_type st_r;
   filt_type st_nxt;

   always_comb
   begin
      logic signed [AW-1:0] x_ext;
      logic signed [AW-1:0] diff;
      int                   yi;
      x_ext  = '0;
      diff   = '0;
      yi     = 0;
      st_nxt = st_r;
      st_nxt.v = 1'b0;
      if (in_valid)
      begin
         x_ext = AW'(in_data) <<< FRAC;
         diff  = x_ext - st_r.acc;
         st_nxt.acc = st_r.acc + (diff >>> filter_shift(filter_code));
         yi = int'(st_nxt.acc >>> FRAC);
         if (yi > span_hi(filter_code))
            yi = span_hi(filter_code);
         else if (yi < span_lo(filter_code))
            yi = span_lo(filter_code);
         st_nxt.y = SW'(yi);
         st_nxt.v = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign out_valid = st_r.v;
   assign out_data  = st_r.y;
endmodule : lp_filter

// ### test/supply_programmer.sv
// external programmer: sends decoded register commands and drives the select level
// assumes the block takes a command on the rising edge while it is ready
`timescale 1ns/1ps
module supply_programmer
(
   input  wire logic                              clock,      // system clock
   input  wire logic                              cmd_ready,  // block idle
   input  wire logic                              resp_valid, // reply strobe
   input  wire logic [hall_cond_pkg::DATA_W-1:0]  resp_data,  // reply word
   output logic                                   cmd_valid,  // command strobe
   output logic                                   cmd_write,  // write flag
   output logic      [hall_cond_pkg::ADDR_W-1:0]  cmd_addr,   // register index
   output logic      [hall_cond_pkg::DATA_W-1:0]  cmd_wdata,  // write data
   output logic                                   select_pin  // selects this sensor
);
   initial
   begin
      cmd_valid  = 1'b0;
      cmd_write  = 1'b0;
      cmd_addr   = 4'h0;
      cmd_wdata  = 16'h0000;
      select_pin = 1'b1;
   end

   // select level on the shared output pin
   task automatic set_select(input logic level);
      select_pin <= level;
   endtask : set_select

   // one command; got stays low when no reply comes
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q, output bit got);
      int n;
      q   = 16'h0000;
      got = 1'b0;
      @(posedge clock);
      for (n = 0; n < 20 && cmd_ready !== 1'b1; n++)
         @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      cmd_addr  <= ~a; // released lines must not show the old value
      cmd_wdata <= ~d;
      for (n = 0; n < 8 && !got; n++)
      begin
         @(posedge clock);
         if (resp_valid === 1'b1)
         begin
            got = 1'b1;
            q   = resp_data;
         end
      end
   endtask : xfer
endmodule : supply_programmer

// ### test/hall_conditioning_bench.sv
// self-checking bench of the field conditioning chain against a register model
// assumes supply_programmer stands in for the external programmer
`timescale 1ns/1ps
module hall_conditioning_bench;
   import hall_cond_pkg::*;
   localparam logic [15:0] TRIM_A = 16'h1357; // arbitrary factory value
   localparam logic [15:0] TRIM_B = 16'h2468; // arbitrary factory value
   localparam logic [15:0] TRIM_C = 16'h0abc; // arbitrary factory value
   logic                       clock, rstn, sample_valid, cmd_valid, cmd_ready, cmd_write;
   logic                       select_pin, resp_valid, out_pin_oe, analog_enable;
   logic                       dac_valid, locked;
   logic signed [SAMPLE_W-1:0] sample_data;
   logic [ADDR_W-1:0]          cmd_addr;
   logic [DATA_W-1:0]          cmd_wdata, resp_data, lin_coef, quad_coef, q;
   logic [DAC_W-1:0]           dac_code, last_dac;
   logic [SEL_W-1:0]           range_sel;
   logic [7:0]                 range_mt;
   logic [15:0]                regs [7];
   bit                         got;
   int                         bad_count, compares, cycles, seed;
   int                         mt [8]    = '{30, 75, 90, 150, 40, 60, 80, 100};
   int                         span_p [5] = '{3967, 1985, 5290, 2645, 1511};
   int                         span_n [5] = '{-3968, -1985, -5292, -2646, -1512};
   int                         fsel [6]   = '{4, 0, 7, 2, 1, 3};

   hall_conditioning #(.TRIM_OSC(TRIM_A), .TRIM_ADC(TRIM_B), .TRIM_SPEC(TRIM_C))
   hall_conditioning_inst (.clock(clock), .rstn(rstn), .sample_valid(sample_valid),
      .sample_data(sample_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .select_pin(select_pin), .resp_valid(resp_valid), .resp_data(resp_data),
      .out_pin_oe(out_pin_oe), .analog_enable(analog_enable), .dac_valid(dac_valid),
      .dac_code(dac_code), .range_sel(range_sel), .range_mt(range_mt),
      .lin_temp_coefficient(lin_coef), .quad_temp_coefficient(quad_coef), .locked(locked));

   supply_programmer programmer_inst (.clock(clock), .cmd_ready(cmd_ready),
      .resp_valid(resp_valid), .resp_data(resp_data), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .select_pin(select_pin));

   task automatic print_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", what, e, s);
         bad_count++;
      end
   endtask : chk

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      programmer_inst.xfer(1'b0, a, 16'h0000, q, got);
      chk("read reply", 16'h0001, 16'(got));
      chk("read word", e, q);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      programmer_inst.xfer(1'b1, a, d, q, got);
      chk("write echo", d, q);
      if (a < 7)
         regs[a] = d;
   endtask : wr

   // constant field for 800 back-to-back samples
   task automatic feed(input int x);
      repeat (800)
      begin
         @(posedge clock);
         sample_valid <= 1'b1;
         sample_data  <= 14'(x);
      end
      @(posedge clock);
      sample_valid <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : feed

   function automatic logic [15:0] exp_dac(input int f);
      int v, hi;
      v  = ((f * int'($signed(regs[1]))) >>> 11) + 2 * int'($signed(regs[2]));
      hi = (regs[4][11:0] < 12'h800) ? int'(regs[4][11:0]) : 2048;
      if (v > hi)
         v = hi;
      if (v < int'(regs[3][11:0]))
         v = int'(regs[3][11:0]);
      return {4'h0, v[11:0]};
   endfunction : exp_dac

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (dac_valid === 1'b1)
         last_dac <= dac_code;
      if (resp_valid === 1'b1)
         chk("pin drive", 16'h0001, {14'h0, analog_enable, out_pin_oe});
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      int i, k, c;
      seed = 32'he453_3fda;
      rstn = 1'b0;
      sample_valid = 1'b0;
      sample_data = '0;
      regs = '{MODE_RESET, SENS_RESET, QUIET_RESET, CLAMP_LOW_RESET, CLAMP_HIGH_RESET,
               COEF_RESET, COEF_RESET};
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      repeat (5) @(posedge clock);
      for (i = 0; i < 7; i++)
         rd(4'(i), regs[i]);
      rd(ADDR_TRIM_OSC, TRIM_A);
      rd(ADDR_TRIM_ADC, TRIM_B);
      rd(ADDR_TRIM_SPEC, TRIM_C);
      rd(4'hc, 16'h0000);
      $display("test reset values done");
      for (i = 0; i < 8; i++)
      begin
         wr(ADDR_MODE, 16'(i));
         chk("range select", 16'(i), {13'h0, range_sel});
         chk("range mT", 16'(mt[i]), {8'h0, range_mt});
      end
      $display("test range codes done");
      for (i = 1; i < 7; i++)
         wr(4'(i), 16'($random(seed)));
      wr(ADDR_TRIM_OSC, 16'($random(seed)));
      for (i = 1; i < 7; i++)
         rd(4'(i), regs[i]);
      rd(ADDR_TRIM_OSC, TRIM_A);
      chk("linear coefficient", regs[5], lin_coef);
      chk("quadratic coefficient", regs[6], quad_coef);
      $display("test register access done");
      wr(ADDR_SENS, 16'h0800);
      wr(ADDR_QUIET, 16'h0000);
      wr(ADDR_CLAMP_LOW, 16'h0100);
      wr(ADDR_CLAMP_HIGH, 16'h0700);
      for (i = 0; i < 6; i++)
      begin
         c = (fsel[i] > 4) ? 0 : fsel[i];
         wr(ADDR_MODE, {10'h0, 3'(fsel[i]), 3'h1});
         for (k = 0; k < 2; k++)
         begin
            feed(k == 0 ? -8192 : 8191);
            rd(ADDR_RAW, 16'(k == 0 ? span_n[c] : span_p[c]));
            chk("output code", exp_dac(k == 0 ? span_n[c] : span_p[c]), {4'h0, last_dac});
         end
      end
      wr(ADDR_QUIET, 16'h0200);
      feed(0);
      rd(ADDR_RAW, 16'h0000);
      chk("zero field code", exp_dac(0), {4'h0, last_dac});
      $display("test sample path done");
      @(posedge clock);
      programmer_inst.set_select(1'b0);
      repeat (6) @(posedge clock);
      programmer_inst.xfer(1'b1, ADDR_SENS, 16'h0123, q, got);
      chk("unselected reply", 16'h0000, 16'(got));
      @(posedge clock);
      programmer_inst.set_select(1'b1);
      repeat (6) @(posedge clock);
      rd(ADDR_SENS, regs[1]);
      $display("test selection done");
      wr(ADDR_LOCK, LOCK_BIT);
      chk("lock state", 16'h0001, {15'h0, locked});
      programmer_inst.xfer(1'b1, ADDR_LIN_COEF, 16'h0321, q, got);
      chk("locked write reply", 16'h0000, 16'(got));
      chk("locked store", regs[5], lin_coef);
      programmer_inst.xfer(1'b0, ADDR_SENS, 16'h0000, q, got);
      chk("locked read reply", 16'h0000, 16'(got));
      chk("ready when refused", 16'h0001, {15'h0, cmd_ready});
      chk("lock kept", 16'h0001, {15'h0, locked});
      $display("test lock done");
      print_verdict();
   end
endmodule : hall_conditioning_bench
